// ==== hdl/cpt_consts.svh ====
// constants for the coprocessor operand transfer engine
`ifndef CPT_CONSTS_SVH
`define CPT_CONSTS_SVH
`define CPT_CIR_OPERAND 5'h0_010
`define CPT_CIR_OPADDR 5'h0_014
`define CPT_PRIM_WRPREV 4'h0_001
`define CPT_PRIM_TAKEADR 4'h0_002
`define CPT_PRIM_STACK 4'h0_003
`define CPT_PRIM_SINGLE 4'h0_004
`define CPT_PRIM_EVALEA 4'h0_005
`define CPT_FC_USER_DATA 3'h0_001
`define CPT_FC_SUPV_DATA 3'h0_005
`define CPT_BYTE_ONE 8'h0_001
`define CPT_BYTE_TWO 8'h0_002
`define CPT_BYTE_FOUR 8'h0_004
`endif

// ==== hdl/cpt_part_size.sv ====
// size of the next operand part
`timescale 1ns/100ps
module cpt_part_size (
   input wire logic [7:0] remain_i,
   output logic [2:0] size_o
);
   // long words first, leftover in one final access
   assign size_o = (remain_i >= 8'h0_004) ? 3'h0_004 : remain_i[2:0];
endmodule

// ==== hdl/cpt_pkg.sv ====
// types shared by the transfer engine files
package cpt_pkg;
   typedef struct packed {
      logic [3:0] kind;
      logic come_again_bit;
      logic direction_bit;
      logic data_addr_sel;
      logic [2:0] reg_num;
      logic [7:0] length;
   } cpt_prim_t;
   typedef struct packed {
      logic [31:0] addr;
      logic [2:0] fc;
      logic [2:0] size;
      logic wr;
   } cpt_bus_req_t;
   typedef enum logic [6:0] {
      CPT_IDLE = 7'b000_0001,
      CPT_GETADR = 7'b000_0010,
      CPT_RDSRC = 7'b000_0100,
      CPT_WRDST = 7'b000_1000,
      CPT_REGMV = 7'b001_0000,
      CPT_VIOL = 7'b010_0000,
      CPT_DONE = 7'b100_0000
   } cpt_state_t;
endpackage

// ==== hdl/cpt_xfer_engine.sv ====
// main processor side engine for operand transfer primitives
// Operation
// - write-to-previous primitive in conditional instruction raises protocol violation
// - write-to-previous length field gives 0 to 255 bytes
// - write-to-previous reads operand port, writes to temporary address
// - three evaluating primitives load the temporary address register; here only the evaluate-address primitive does
// - write target undefined without prior evaluation or register direct
// - write function code follows supervisor bit sampled at primitive read
// - no check of addressing mode behind stored address
// - long-word parts ascending, final one to three byte part
// - write-to-previous leaves programmer registers unchanged
// - take-address never overwrites the temporary address register
// - read then write forms an unlocked read-modify-write
// - take, stack, single allowed conditional only with come-again set
// - take-address length 0 to 255 bytes
// - take-address reads 32-bit address, then moves parts by direction
// - supplied address accesses use supervisor or user data code
// - stack primitive lengths only 1, 2 or 4; others violate
// - direction clear pops with postincrement, byte adds two
// - direction set pushes with predecrement, byte subtracts two
// - single-register primitive moves register through operand port
// - select bit zero data register, one address register
// - direction clear writes register to port, set reads port
// - direction zero processor to coprocessor, one reverse
`timescale 1ns/100ps
`include "cpt_consts.svh"
module cpt_xfer_engine
   import cpt_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic prim_valid_i,
   input wire cpt_prim_t prim_i,
   input wire logic cond_instr_i,
   input wire logic supervisor_i,
   input wire logic [31:0] eval_addr_i,
   input wire logic bus_ack_i,
   input wire logic [31:0] bus_rdata_i,
   input wire logic [4:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   output logic bus_req_o,
   output cpt_bus_req_t bus_o,
   output logic bus_lock_o,
   output logic [31:0] bus_wdata_o,
   output logic cir_req_o,
   output logic cir_wr_o,
   output logic [4:0] cir_addr_o,
   output logic [31:0] cir_wdata_o,
   output logic [31:0] active_stack_pointer_o,
   output logic prot_viol_o,
   output logic busy_o,
   output logic done_o
);
   cpt_state_t state_q, state_d;
   cpt_prim_t prim_q;
   logic [31:0] tmp_addr_q;
   logic [31:0] cur_addr_q;
   logic [31:0] part_q;
   logic [7:0] remain_q;
   logic [2:0] fc_q;
   logic [31:0] regs_q [0:15];
   logic [31:0] active_stack_pointer_q;
   logic [31:0] rdata_q;
   logic [2:0] part_size;
   logic bus_wait_q;

   function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [2:0] s);
      step_addr = a + {29'h0_0000_000, s};
   endfunction

   // bank bit on top of the register number
   function automatic logic [3:0] reg_index(input cpt_prim_t p);
      reg_index = {p.data_addr_sel, p.reg_num};
   endfunction

   // functional decode
   // shared primitive layout
   wire in_wrprev = prim_i.kind == `CPT_PRIM_WRPREV;
   wire in_cond_ok = prim_i.come_again_bit;
   wire in_stack_len_ok = (prim_i.length == `CPT_BYTE_ONE) || (prim_i.length == `CPT_BYTE_TWO)
      || (prim_i.length == `CPT_BYTE_FOUR);
   wire in_known = (prim_i.kind == `CPT_PRIM_TAKEADR) || (prim_i.kind == `CPT_PRIM_STACK)
      || (prim_i.kind == `CPT_PRIM_SINGLE) || in_wrprev;
   wire viol_wrprev = in_wrprev && cond_instr_i;
   wire viol_cond = !in_wrprev && cond_instr_i && !in_cond_ok;
   wire viol_len = (prim_i.kind == `CPT_PRIM_STACK) && !in_stack_len_ok;
   wire in_viol = viol_wrprev || viol_cond || viol_len;
   wire [3:0] reg_idx = reg_index(prim_q);
   // byte push moves pointer by two
   wire [31:0] stack_step = (prim_i.length == `CPT_BYTE_ONE) ? 32'h0_0000_0002
      : {24'h00_0000, prim_i.length};
   // acknowledge only counts for the access still outstanding
   wire bus_done = bus_wait_q && bus_ack_i;
   // operand port answers in the cycle of its strobe
   wire cir_done = cir_req_o;
   // port or memory side of each half of a part
   wire rd_done = prim_q.direction_bit ? cir_done : bus_done;
   wire wr_done = prim_q.direction_bit ? bus_done : cir_done;
   // final part when the rest fits one access
   wire last_part = remain_q == {5'h00, part_size};
   wire xfer_state = (state_q == CPT_RDSRC) || (state_q == CPT_WRDST);
   // one access at a time, a new one waits for the previous answer
   wire xfer_go = xfer_state && !bus_wait_q && !cir_req_o && (state_d == state_q);
   wire port_side = (state_q == CPT_RDSRC) == prim_q.direction_bit;
   wire bus_issue = xfer_go && !port_side;

   cpt_part_size u_part_size (
      .remain_i(remain_q),
      .size_o(part_size)
   );

   always_comb begin
      state_d = state_q;
      case (state_q)
         CPT_IDLE: begin
            // unknown kinds ignored, engine stays idle
            if (prim_valid_i && in_known) begin
               if (in_viol) begin
                  state_d = CPT_VIOL;
               end else if (prim_i.kind == `CPT_PRIM_TAKEADR) begin
                  state_d = CPT_GETADR;
               end else if (prim_i.kind == `CPT_PRIM_SINGLE) begin
                  state_d = CPT_REGMV;
               end else if (prim_i.length == 8'h0_000) begin
                  state_d = CPT_DONE;
               end else begin
                  state_d = CPT_RDSRC;
               end
            end
         end
         CPT_GETADR: begin
            if (cir_done) begin
               state_d = (remain_q == 8'h0_000) ? CPT_DONE : CPT_RDSRC;
            end
         end
         CPT_RDSRC: begin
            if (rd_done) begin
               state_d = CPT_WRDST;
            end
         end
         CPT_WRDST: begin
            if (wr_done) begin
               state_d = last_part ? CPT_DONE : CPT_RDSRC;
            end
         end
         CPT_REGMV: begin
            if (cir_done) begin
               state_d = CPT_DONE;
            end
         end
         CPT_VIOL: state_d = CPT_DONE;
         CPT_DONE: state_d = CPT_IDLE;
         default: state_d = CPT_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= CPT_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // latch primitive and its fields
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prim_q <= '0;
         fc_q <= `CPT_FC_USER_DATA;
      end else if (state_q == CPT_IDLE && prim_valid_i) begin
         prim_q <= prim_i;
         if (in_wrprev) begin
            prim_q.direction_bit <= 1'b1;
         end
         fc_q <= supervisor_i ? `CPT_FC_SUPV_DATA : `CPT_FC_USER_DATA;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tmp_addr_q <= '0;
      end else if (prim_valid_i && prim_i.kind == `CPT_PRIM_EVALEA) begin
         tmp_addr_q <= eval_addr_i;
      end
   end

   // address and count tracking
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cur_addr_q <= '0;
         remain_q <= '0;
         active_stack_pointer_q <= '0;
      end else if (state_q == CPT_IDLE && prim_valid_i && !in_viol) begin
         remain_q <= prim_i.length;
         if (in_wrprev) begin
            cur_addr_q <= tmp_addr_q;
         end else if (prim_i.kind == `CPT_PRIM_STACK && prim_i.direction_bit) begin
            active_stack_pointer_q <= active_stack_pointer_q - stack_step;
            cur_addr_q <= active_stack_pointer_q - stack_step;
         end else if (prim_i.kind == `CPT_PRIM_STACK) begin
            cur_addr_q <= active_stack_pointer_q;
            active_stack_pointer_q <= active_stack_pointer_q + stack_step;
         end
      end else if (state_q == CPT_GETADR && cir_done) begin
         cur_addr_q <= bus_rdata_i;
      end else if (state_q == CPT_WRDST && wr_done) begin
         cur_addr_q <= step_addr(cur_addr_q, part_size);
         remain_q <= remain_q - {5'h00, part_size};
      end else if (state_q == CPT_IDLE && reg_wr_i && reg_addr_i == 5'h0_01f) begin
         active_stack_pointer_q <= reg_wdata_i;
      end
   end

   // part holding register
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         part_q <= '0;
      end else if (state_q == CPT_RDSRC && rd_done) begin
         part_q <= bus_rdata_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 16; i++) begin
            regs_q[i] <= '0;
         end
      end else if (state_q == CPT_REGMV && cir_done && prim_q.direction_bit) begin
         regs_q[reg_idx[3:0]] <= bus_rdata_i;
      end else if (state_q == CPT_IDLE && reg_wr_i && !reg_addr_i[4]) begin
         regs_q[reg_addr_i[3:0]] <= reg_wdata_i;
      end
   end

   // register readback port
   // temp address readable, never writable
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= '0;
      end else if (reg_rd_i) begin
         if (!reg_addr_i[4]) begin
            rdata_q <= regs_q[reg_addr_i[3:0]];
         end else if (reg_addr_i == 5'h0_01f) begin
            rdata_q <= active_stack_pointer_q;
         end else if (reg_addr_i == 5'h0_01e) begin
            rdata_q <= tmp_addr_q;
         end else begin
            rdata_q <= '0;
         end
      end
   end

   // bus and operand port strobes
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_req_o <= 1'b0;
         bus_o <= '0;
         bus_wdata_o <= '0;
         cir_req_o <= 1'b0;
         cir_wr_o <= 1'b0;
         cir_addr_o <= '0;
         cir_wdata_o <= '0;
      end else begin
         bus_req_o <= 1'b0;
         cir_req_o <= 1'b0;
         if (state_d == CPT_GETADR && !cir_req_o) begin
            cir_req_o <= 1'b1;
            cir_wr_o <= 1'b0;
            cir_addr_o <= `CPT_CIR_OPADDR;
         end else if (state_d == CPT_REGMV && !cir_req_o) begin
            // register via operand port
            // offered fields, prim_q only loads at this edge
            cir_req_o <= 1'b1;
            cir_wr_o <= !prim_i.direction_bit;
            cir_addr_o <= `CPT_CIR_OPERAND;
            cir_wdata_o <= regs_q[reg_index(prim_i)];
         end else if (xfer_go) begin
            // unlocked cycles, bus may be granted between
            if (port_side) begin
               cir_req_o <= 1'b1;
               cir_wr_o <= !prim_q.direction_bit;
               cir_addr_o <= `CPT_CIR_OPERAND;
               cir_wdata_o <= part_q;
            end else begin
               bus_req_o <= 1'b1;
               bus_o <= '{addr: cur_addr_q, fc: fc_q, size: part_size,
                  wr: prim_q.direction_bit};
               bus_wdata_o <= part_q;
            end
         end
      end
   end

   // one access outstanding until its acknowledge
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_wait_q <= 1'b0;
      end else if (bus_issue) begin
         bus_wait_q <= 1'b1;
      end else if (bus_ack_i) begin
         bus_wait_q <= 1'b0;
      end
   end

   // status outputs
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prot_viol_o <= 1'b0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         bus_lock_o <= 1'b0;
      end else begin
         prot_viol_o <= state_d == CPT_VIOL;
         busy_o <= state_d != CPT_IDLE;
         done_o <= state_d == CPT_DONE;
         bus_lock_o <= 1'b0;
      end
   end

   assign reg_rdata_o = rdata_q;
   assign active_stack_pointer_o = active_stack_pointer_q;
endmodule

// ==== testbench/cpt_chk_assertions.sv ====
// port assertions for the transfer engine
`timescale 1ns/100ps
`include "cpt_consts.svh"
module cpt_chk
   import cpt_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic prim_valid_i,
   input wire cpt_prim_t prim_i,
   input wire logic cond_instr_i,
   input wire logic busy_o,
   input wire logic done_o,
   input wire logic prot_viol_o,
   input wire logic bus_req_o,
   input wire cpt_bus_req_t bus_o,
   input wire logic bus_lock_o,
   input wire logic [31:0] active_stack_pointer_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   wire take = prim_valid_i && !busy_o;
   wire [3:0] k = prim_i.kind;
   wire [31:0] sp = active_stack_pointer_o;
   a_lock_low: assert property (!bus_lock_o) else $error("bus locked");
   a_wrprev_cond: assert property (take && k == `CPT_PRIM_WRPREV && cond_instr_i
      |-> ##[1:3] prot_viol_o) else $error("no violation on write-previous");
   a_ca_cond: assert property (take && cond_instr_i && !prim_i.come_again_bit
      && k inside {`CPT_PRIM_TAKEADR, `CPT_PRIM_STACK, `CPT_PRIM_SINGLE}
      |-> ##[1:3] prot_viol_o) else $error("no violation on cleared come-again");
   a_stack_len: assert property (take && k == `CPT_PRIM_STACK
      && !(prim_i.length inside {`CPT_BYTE_ONE, `CPT_BYTE_TWO, `CPT_BYTE_FOUR})
      |-> ##[1:3] prot_viol_o) else $error("bad stack length taken");
   a_viol_done: assert property (prot_viol_o |-> ##[0:2] done_o) else $error("no done");
   a_data_fc: assert property (bus_req_o
      |-> bus_o.fc == `CPT_FC_USER_DATA || bus_o.fc == `CPT_FC_SUPV_DATA)
      else $error("not a data space code");
   a_part_size: assert property (bus_req_o |-> bus_o.size inside {[3'h1:3'h4]})
      else $error("bad part size");
   a_sp_step: assert property (busy_o && $changed(sp)
      |-> (sp - $past(sp)) inside {32'h0000_0002, 32'h0000_0004, 32'hffff_fffe,
      32'hffff_fffc}) else $error("bad stack pointer step");
endmodule
bind cpt_xfer_engine cpt_chk u_chk (.ref_clk_i, .rst_n_i, .prim_valid_i, .prim_i,
   .cond_instr_i, .busy_o, .done_o, .prot_viol_o, .bus_req_o, .bus_o, .bus_lock_o,
   .active_stack_pointer_o);

// ==== testbench/cpt_far.sv ====
// far side model: coprocessor registers and data memory
`timescale 1ns/100ps
`include "cpt_consts.svh"
module cpt_far (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic bus_req_i,
   input wire logic [31:0] bus_addr_i,
   input wire logic cir_req_i,
   input wire logic cir_wr_i,
   input wire logic [4:0] cir_addr_i,
   input wire logic slow_i,
   input wire logic [31:0] take_addr_i,
   input wire logic [31:0] port_data_i,
   output logic bus_ack_o,
   output logic [31:0] bus_rdata_o
);
   logic [2:0] wait_q;
   logic [31:0] mem_q;
   logic [31:0] last_q;
   wire port_rd = cir_req_i && !cir_wr_i;
   wire [31:0] port_q = (cir_addr_i == `CPT_CIR_OPADDR) ? take_addr_i : port_data_i;
   // port read gives coprocessor data; idle lines keep toggling
   assign bus_rdata_o = port_rd ? port_q : (bus_ack_o ? mem_q : ~last_q);
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_q <= 3'h0;
         bus_ack_o <= 1'b0;
         mem_q <= 32'h0000_0000;
         last_q <= 32'h0000_0000;
      end else begin
         bus_ack_o <= (wait_q == 3'h1);
         last_q <= bus_rdata_o;
         if (bus_req_i) begin
            wait_q <= slow_i ? 3'h3 : 3'h1;
            mem_q <= ~bus_addr_i;
         end else if (wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
         end
      end
   end
endmodule

// ==== testbench/cpt_xfer_engine_tb_top.sv ====
// self-checking bench for the transfer engine
`timescale 1ns/100ps
`include "cpt_consts.svh"
module cpt_xfer_engine_tb_top
   import cpt_pkg::*;
;
   logic ref_clk_i = 1'b0, rst_n_i = 1'b0, prim_valid_i = 1'b0, cond_instr_i = 1'b0;
   logic supervisor_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, slow = 1'b0;
   cpt_prim_t prim_i = '0;
   logic [31:0] eval_addr_i = 32'h0000_1000, take_addr = 32'h0000_2000;
   logic [31:0] port_data = 32'h1234_5678, reg_wdata_i = 32'h0000_0000;
   logic [4:0] reg_addr_i = 5'h00;
   logic bus_ack_i, bus_req_o, bus_lock_o, cir_req_o, cir_wr_o, prot_viol_o, busy_o, done_o;
   logic [31:0] bus_rdata_i, reg_rdata_o, bus_wdata_o, cir_wdata_o, sp;
   cpt_bus_req_t bus_o;
   logic [4:0] cir_addr_o, aq[$];
   logic [38:0] bq[$];
   logic [31:0] cq[$], wq[$];
   int nv, n_mismatch, cmp_count;
   cpt_xfer_engine u_dut (.ref_clk_i, .rst_n_i, .prim_valid_i, .prim_i, .cond_instr_i,
      .supervisor_i, .eval_addr_i, .bus_ack_i, .bus_rdata_i, .reg_addr_i, .reg_wdata_i,
      .reg_wr_i, .reg_rd_i, .reg_rdata_o, .bus_req_o, .bus_o, .bus_lock_o, .bus_wdata_o,
      .cir_req_o, .cir_wr_o, .cir_addr_o, .cir_wdata_o, .active_stack_pointer_o(sp),
      .prot_viol_o, .busy_o, .done_o);
   cpt_far u_far (.ref_clk_i, .rst_n_i, .bus_req_i(bus_req_o), .bus_addr_i(bus_o.addr),
      .cir_req_i(cir_req_o), .cir_wr_i(cir_wr_o), .cir_addr_i(cir_addr_o), .slow_i(slow),
      .take_addr_i(take_addr), .port_data_i(port_data), .bus_ack_o(bus_ack_i),
      .bus_rdata_o(bus_rdata_i));
   initial forever #5 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      if (bus_req_o === 1'b1) bq.push_back(bus_o);
      if (bus_req_o === 1'b1 && bus_o.wr === 1'b1) wq.push_back(bus_wdata_o);
      if (cir_req_o === 1'b1 && cir_wr_o === 1'b1) cq.push_back(cir_wdata_o);
      if (cir_req_o === 1'b1) aq.push_back(cir_addr_o);
      if (prot_viol_o === 1'b1) nv++;
   end
   task automatic chk(input logic [38:0] got, input logic [38:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      if (n_mismatch == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wreg(input logic [4:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rreg(input logic [4:0] a, input logic [31:0] e);
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      @(negedge ref_clk_i);
      chk(39'(reg_rdata_o), 39'(e));
   endtask
   // primitive fields packed in the shared layout
   task automatic run(input logic [3:0] k, input logic ca, dr, da, input logic [2:0] rn,
      input logic [7:0] ln);
      int n;
      @(negedge ref_clk_i);
      bq.delete();
      cq.delete();
      wq.delete();
      aq.delete();
      nv = 0;
      @(posedge ref_clk_i);
      prim_valid_i <= 1'b1;
      prim_i <= {k, ca, dr, da, rn, ln};
      @(posedge ref_clk_i);
      prim_valid_i <= 1'b0;
      if (k == `CPT_PRIM_EVALEA) return;
      for (n = 0; n < 300 && done_o !== 1'b1; n++)
         @(negedge ref_clk_i);
      if (n == 300) chk(39'h1, 39'h0);
      @(posedge ref_clk_i);
   endtask
   task automatic stk(input logic dr, input logic [7:0] ln, input logic [2:0] sz,
      input logic [31:0] a, input logic [31:0] s);
      run(`CPT_PRIM_STACK, 1'b1, dr, 1'b0, 3'h0, ln);
      chk(bq[0], {a, `CPT_FC_USER_DATA, sz, dr});
      chk(39'(sp), 39'(s));
   endtask
   initial begin
      #200_000;
      n_mismatch++;
      end_sim();
   end
   initial begin
      repeat (4) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      chk({busy_o, done_o, prot_viol_o, bus_req_o, bus_lock_o, cir_req_o}, '0);
      run(`CPT_PRIM_EVALEA, 1'b1, 1'b0, 1'b0, 3'h0, 8'h00);
      rreg(5'h1e, 32'h0000_1000);
      run(`CPT_PRIM_WRPREV, 1'b1, 1'b0, 1'b0, 3'h0, 8'h07);
      chk(bq[0], {32'h0000_1000, `CPT_FC_SUPV_DATA, 3'h4, 1'b1});
      chk(bq[1], {32'h0000_1004, `CPT_FC_SUPV_DATA, 3'h3, 1'b1});
      chk(39'(wq[0]), 39'(port_data));
      chk(39'(sp), 39'h0);
      supervisor_i <= 1'b0;
      slow <= 1'b1;
      run(`CPT_PRIM_TAKEADR, 1'b1, 1'b0, 1'b0, 3'h0, 8'h05);
      chk(bq[0], {32'h0000_2000, `CPT_FC_USER_DATA, 3'h4, 1'b0});
      chk(bq[1], {32'h0000_2004, `CPT_FC_USER_DATA, 3'h1, 1'b0});
      chk(39'(aq[0]), 39'(`CPT_CIR_OPADDR));
      chk(39'(aq[1]), 39'(`CPT_CIR_OPERAND));
      chk(39'(cq[0]), 39'(32'hffff_dfff));
      run(`CPT_PRIM_TAKEADR, 1'b1, 1'b1, 1'b0, 3'h0, 8'h04);
      chk(39'(wq[0]), 39'(port_data));
      rreg(5'h1e, 32'h0000_1000);
      run(`CPT_PRIM_WRPREV, 1'b1, 1'b1, 1'b0, 3'h0, 8'h00);
      chk(39'(bq.size()), 39'h0);
      cond_instr_i <= 1'b1;
      run(`CPT_PRIM_WRPREV, 1'b1, 1'b1, 1'b0, 3'h0, 8'h04);
      chk(39'(nv), 39'h1);
      for (int i = 2; i < 5; i++) begin
         run(4'(i), 1'b0, 1'b0, 1'b0, 3'h0, 8'h04);
         chk(39'(nv), 39'h1);
         run(4'(i), 1'b1, 1'b0, 1'b0, 3'h0, 8'h04);
         chk(39'(nv), 39'h0);
      end
      cond_instr_i <= 1'b0;
      for (int l = 0; l < 9; l += 3) begin
         run(`CPT_PRIM_STACK, 1'b1, 1'b0, 1'b0, 3'h0, 8'(l));
         chk(39'(nv), 39'h1);
      end
      wreg(5'h1f, 32'h0000_8000);
      stk(1'b0, 8'h01, 3'h1, 32'h0000_8000, 32'h0000_8002);
      stk(1'b1, 8'h01, 3'h1, 32'h0000_8000, 32'h0000_8000);
      stk(1'b1, 8'h04, 3'h4, 32'h0000_7ffc, 32'h0000_7ffc);
      stk(1'b0, 8'h02, 3'h2, 32'h0000_7ffc, 32'h0000_7ffe);
      wreg(5'h03, 32'hcafe_0003);
      run(`CPT_PRIM_SINGLE, 1'b1, 1'b0, 1'b0, 3'h3, 8'h04);
      chk(39'(cq[0]), 39'(32'hcafe_0003));
      port_data <= 32'h0bad_f00d;
      run(`CPT_PRIM_SINGLE, 1'b1, 1'b1, 1'b1, 3'h2, 8'h04);
      rreg(5'h0a, 32'h0bad_f00d);
      rreg(5'h03, 32'hcafe_0003);
      end_sim();
   end
endmodule
